// File: rtl/iobs_top.sv
// io bank select: routes pin commands to the main or auxiliary bank
`timescale 1ns/1ps
module iobs_top
  import iobs_pkg::*;
#(
  parameter bit AUX_PRESENT = 1'b1
) (
  // clock, reset, enable
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  input  wire logic        CE,
  // interpreter command
  input  wire logic        CMD_VALID,
  input  wire iobs_cmd_t   CMD,
  // main physical pins
  input  wire logic [15:0] MAIN_PIN_IN,
  output logic      [15:0] MAIN_PIN_OUT,
  output logic      [15:0] MAIN_PIN_OE_N,
  // auxiliary physical pins
  input  wire logic [15:0] AUX_PIN_IN,
  output logic      [15:0] AUX_PIN_OUT,
  output logic      [15:0] AUX_PIN_OE_N,
  // status back to the interpreter
  output iobs_bank_t       BANK_SEL,
  output logic      [15:0] SEL_PIN_READ,
  output logic      [15:0] SEL_DIR_READ,
  output logic      [15:0] SEL_OUT_READ
);
  // a command acts on the bank selected before it, so a select followed
  // at once by a pin command already steers that pin command
  // pins and readback show each effect one edge after the command edge
  // a low enable freezes every register, the bank selection included
  // the auxiliary state is kept even when its pins are absent, so a
  // later select reads back what was written before

  // selection state and its next value
  iobs_bank_t       bank_q;
  iobs_bank_t       bank_d;

  // command strobes towards the two banks
  logic             cmd_go;
  logic             main_hit;
  logic             aux_hit;

  // state words of both banks and of the selected one
  iobs_bank_state_t main_st;
  iobs_bank_state_t aux_st;
  iobs_bank_state_t sel_st;

  // pin levels as the selected-bank read sees them
  logic [15:0]      aux_in_eff;
  logic [15:0]      sel_pin_d;

  // next values of the pin drive and readback registers
  logic [15:0]      main_out_d;
  logic [15:0]      main_oe_n_d;
  logic [15:0]      aux_out_d;
  logic [15:0]      aux_oe_n_d;
  logic [15:0]      sel_dir_d;
  logic [15:0]      sel_out_d;

  // true when the given bank is the auxiliary one
  function automatic logic is_aux(input iobs_bank_t b);
    return b == IOBS_BANK_AUX;
  endfunction

  // pick the auxiliary or the main word by bank
  function automatic logic [15:0] pick_word(
    input iobs_bank_t  b,
    input logic [15:0] aux_w,
    input logic [15:0] main_w
  );
    return is_aux(b) ? aux_w : main_w;
  endfunction

  // a variant without auxiliary pins shows the idle word instead
  function automatic logic [15:0] aux_gate(
    input logic [15:0] live_w,
    input logic [15:0] idle_w
  );
    return AUX_PRESENT ? live_w : idle_w;
  endfunction

  // a command counts only on an enabled edge
  assign cmd_go = CE && CMD_VALID;

  // a command reaches the bank selected before it, never both
  assign main_hit = CMD_VALID && !is_aux(bank_q);
  assign aux_hit  = CMD_VALID && is_aux(bank_q);

  // next bank from the select commands; other ops keep it
  always_comb begin
    bank_d = bank_q;
    if (cmd_go) begin
      case (CMD.op)
        IOBS_OP_SEL_MAIN:  bank_d = IOBS_BANK_MAIN;
        IOBS_OP_SEL_AUX:   bank_d = IOBS_BANK_AUX;
        IOBS_OP_SEL_VALUE: bank_d = CMD.sel_value ? IOBS_BANK_AUX : IOBS_BANK_MAIN;
        default:           bank_d = bank_q;
      endcase
    end
  end

  // bank selection persists until changed or reset
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      bank_q <= IOBS_BANK_MAIN;
    end else if (CE) begin
      bank_q <= bank_d;
    end
  end

  // two independent banks sharing pin ids 0-15
  iobs_bank #(.WIDTH(PIN_COUNT)) u_main (
    .clk   (SYS_CLK),
    .rst   (RST),
    .ce    (CE),
    .hit   (main_hit),
    .cmd   (CMD),
    .state (main_st)
  );

  // the auxiliary bank keeps its words even with no pins behind it
  iobs_bank #(.WIDTH(PIN_COUNT)) u_aux (
    .clk   (SYS_CLK),
    .rst   (RST),
    .ce    (CE),
    .hit   (aux_hit),
    .cmd   (CMD),
    .state (aux_st)
  );

  // absent aux inputs read as pulled high
  assign aux_in_eff = aux_gate(AUX_PIN_IN, PULLUP_ONES);
  assign sel_pin_d  = pick_word(bank_q, aux_in_eff, MAIN_PIN_IN);
  assign sel_st     = is_aux(bank_q) ? aux_st : main_st;

  // pin drive from the bank words; a set direction bit drives the pin
  always_comb begin
    main_out_d  = main_st.outv;
    main_oe_n_d = ~main_st.dir;
    aux_out_d   = aux_gate(aux_st.outv, OUT_RESET);
    aux_oe_n_d  = aux_gate(~aux_st.dir, ~DIR_RESET);
  end

  // readback words of the selected bank
  always_comb begin
    sel_dir_d = sel_st.dir;
    sel_out_d = sel_st.outv;
  end

  // bank status lags the internal selection by one edge
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      BANK_SEL <= IOBS_BANK_MAIN;
    end else if (CE) begin
      BANK_SEL <= bank_q;
    end
  end

  // main pin levels
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      MAIN_PIN_OUT <= OUT_RESET;
    end else if (CE) begin
      MAIN_PIN_OUT <= main_out_d;
    end
  end

  // main pin enables, low while driving
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      MAIN_PIN_OE_N <= ~DIR_RESET;
    end else if (CE) begin
      MAIN_PIN_OE_N <= main_oe_n_d;
    end
  end

  // auxiliary pin levels
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      AUX_PIN_OUT <= OUT_RESET;
    end else if (CE) begin
      AUX_PIN_OUT <= aux_out_d;
    end
  end

  // auxiliary pin enables, never low when the pins are absent
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      AUX_PIN_OE_N <= ~DIR_RESET;
    end else if (CE) begin
      AUX_PIN_OE_N <= aux_oe_n_d;
    end
  end

  // pin levels of the selected bank
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      SEL_PIN_READ <= 16'h0000;
    end else if (CE) begin
      SEL_PIN_READ <= sel_pin_d;
    end
  end

  // direction word of the selected bank
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      SEL_DIR_READ <= DIR_RESET;
    end else if (CE) begin
      SEL_DIR_READ <= sel_dir_d;
    end
  end

  // output word of the selected bank
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      SEL_OUT_READ <= OUT_RESET;
    end else if (CE) begin
      SEL_OUT_READ <= sel_out_d;
    end
  end
endmodule

// File: rtl/iobs_pkg.sv
// package of constants and carriers for the io bank select block
package iobs_pkg;
  localparam int          PIN_COUNT   = 16;
  localparam int          ID_W        = 4;
  localparam logic [15:0] DIR_RESET   = 16'h0000;
  localparam logic [15:0] OUT_RESET   = 16'h0000;
  localparam logic [15:0] PULLUP_ONES = 16'hFFFF;

  // bank identifiers
  typedef enum logic {
    IOBS_BANK_MAIN = 1'b0,
    IOBS_BANK_AUX  = 1'b1
  } iobs_bank_t;

  // command opcodes from the interpreter
  typedef enum logic [3:0] {
    IOBS_OP_NONE,
    IOBS_OP_SEL_MAIN,
    IOBS_OP_SEL_AUX,
    IOBS_OP_SEL_VALUE,
    IOBS_OP_WR_DIR_WORD,
    IOBS_OP_WR_OUT_WORD,
    IOBS_OP_PIN_INPUT,
    IOBS_OP_PIN_OUTPUT,
    IOBS_OP_PIN_LOW,
    IOBS_OP_PIN_HIGH,
    IOBS_OP_PIN_TOGGLE,
    IOBS_OP_PIN_REVERSE
  } iobs_op_t;

  // one command with its operands
  typedef struct packed {
    iobs_op_t         op;
    logic [ID_W-1:0]  pin_id;
    logic             sel_value;
    logic [15:0]      word;
  } iobs_cmd_t;

  // direction and output state of one bank
  typedef struct packed {
    logic [15:0] dir;
    logic [15:0] outv;
  } iobs_bank_state_t;
endpackage

// File: rtl/iobs_bank.sv
// one bank of sixteen pins: direction and output words
`timescale 1ns/1ps
module iobs_bank
  import iobs_pkg::*;
#(
  parameter int WIDTH = PIN_COUNT
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // command for this bank, valid only when selected
  input  wire logic             hit,
  input  wire iobs_cmd_t        cmd,
  // state
  output iobs_bank_state_t      state
);
  logic [WIDTH-1:0] dir_q;
  logic [WIDTH-1:0] out_q;
  logic [WIDTH-1:0] bit_m;

  assign bit_m = WIDTH'(1) << cmd.pin_id;

  // direction word, held unless this bank is hit
  always_ff @(posedge clk) begin
    if (rst) begin
      dir_q <= DIR_RESET[WIDTH-1:0];
    end else if (ce && hit) begin
      case (cmd.op)
        IOBS_OP_WR_DIR_WORD: dir_q <= cmd.word[WIDTH-1:0];
        IOBS_OP_PIN_INPUT:   dir_q <= dir_q & ~bit_m;
        IOBS_OP_PIN_OUTPUT,
        IOBS_OP_PIN_LOW,
        IOBS_OP_PIN_HIGH,
        IOBS_OP_PIN_TOGGLE:  dir_q <= dir_q | bit_m;
        IOBS_OP_PIN_REVERSE: dir_q <= dir_q ^ bit_m;
        default:             dir_q <= dir_q;
      endcase
    end
  end

  // output word, held unless this bank is hit
  always_ff @(posedge clk) begin
    if (rst) begin
      out_q <= OUT_RESET[WIDTH-1:0];
    end else if (ce && hit) begin
      case (cmd.op)
        IOBS_OP_WR_OUT_WORD: out_q <= cmd.word[WIDTH-1:0];
        IOBS_OP_PIN_LOW:     out_q <= out_q & ~bit_m;
        IOBS_OP_PIN_HIGH:    out_q <= out_q | bit_m;
        IOBS_OP_PIN_TOGGLE:  out_q <= out_q ^ bit_m;
        default:             out_q <= out_q;
      endcase
    end
  end

  assign state.dir  = dir_q;
  assign state.outv = out_q;
endmodule

// File: test/iobs_pins.sv
// far-side pin model for one bank
`timescale 1ns/1ps
module iobs_pins (
  input  wire logic        clk,
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe_n,
  output logic      [15:0] pin_in
);
  logic [15:0] wander_q = 16'hA5A5;
  // floating pins flip every cycle so a stale level never passes
  always_ff @(posedge clk) wander_q <= ~wander_q;
  assign pin_in = (pin_out & ~pin_oe_n) | (wander_q & pin_oe_n);
endmodule

// File: test/iobs_monitor.sv
// checker on the io bank select top ports
`timescale 1ns/1ps
module iobs_monitor
  import iobs_pkg::*;
#(
  parameter bit AUX_ON = 1'b1
) (
  // clock and command
  input wire logic        SYS_CLK,
  input wire logic        RST,
  input wire logic        CE,
  input wire logic        CMD_VALID,
  input wire iobs_cmd_t   CMD,
  // pins and status
  input wire logic [15:0] MAIN_PIN_OUT,
  input wire logic [15:0] MAIN_PIN_OE_N,
  input wire logic [15:0] AUX_PIN_OUT,
  input wire logic [15:0] AUX_PIN_OE_N,
  input wire iobs_bank_t  BANK_SEL
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  logic quiet_q;
  // a quiet cycle before lets bank status match the internal bank
  always_ff @(posedge SYS_CLK) quiet_q <= CE && !CMD_VALID;
  wire take = CE && CMD_VALID;
  wire sel = take && CMD.op inside {[IOBS_OP_SEL_MAIN:IOBS_OP_SEL_VALUE]};
  wire q_aux = take && quiet_q && BANK_SEL == IOBS_BANK_AUX;
  wire q_main = take && quiet_q && BANK_SEL == IOBS_BANK_MAIN;
  wire q_live = AUX_ON && q_aux;
  sel_aux_a: assert property (take && CMD.op == IOBS_OP_SEL_AUX ##1 CE |-> ##1
    BANK_SEL == IOBS_BANK_AUX) else $error("aux select lost");
  sel_val_a: assert property (take && CMD.op == IOBS_OP_SEL_VALUE ##1 CE |-> ##1
    BANK_SEL == $past(CMD.sel_value, 2)) else $error("value select wrong");
  sel_keep_a: assert property (CE && !sel |-> ##2 $stable(BANK_SEL))
    else $error("bank moved");
  reset_clear_a: assert property (disable iff (1'b0) RST && CE |=> MAIN_PIN_OE_N == 16'hFFFF
    && AUX_PIN_OE_N == 16'hFFFF && !MAIN_PIN_OUT && !AUX_PIN_OUT) else $error("reset state");
  main_high_a: assert property (q_main && CMD.op == IOBS_OP_PIN_HIGH ##1 CE |-> ##1
    MAIN_PIN_OUT[$past(CMD.pin_id, 2)] && !MAIN_PIN_OE_N[$past(CMD.pin_id, 2)])
    else $error("main high missed");
  aux_low_a: assert property (q_live && CMD.op == IOBS_OP_PIN_LOW ##1 CE |-> ##1
    !AUX_PIN_OUT[$past(CMD.pin_id, 2)] && !AUX_PIN_OE_N[$past(CMD.pin_id, 2)])
    else $error("aux low missed");
  main_still_a: assert property (q_aux ##1 CE |-> ##1 $stable(MAIN_PIN_OUT) &&
    $stable(MAIN_PIN_OE_N)) else $error("main bank disturbed");
  aux_dir_a: assert property (q_live && CMD.op == IOBS_OP_WR_DIR_WORD ##1 CE |-> ##1
    AUX_PIN_OE_N == ~$past(CMD.word, 2)) else $error("aux direction wrong");
  cover property (q_aux && CMD.op == IOBS_OP_PIN_LOW);
  cover property (q_main && CMD.op == IOBS_OP_PIN_HIGH);
  aux_idle_a: assert property (!AUX_ON |-> AUX_PIN_OE_N == 16'hFFFF && !AUX_PIN_OUT)
    else $error("absent aux pins driven");
  cover property (take && CMD.op == IOBS_OP_SEL_VALUE && CMD.sel_value);
  cover property (!AUX_ON && BANK_SEL == IOBS_BANK_AUX);
endmodule

// File: test/io_bank_select_tb.sv
// self-checking bench for io bank select
`timescale 1ns/1ps
module io_bank_select_tb
  import iobs_pkg::*;
;
  logic        SYS_CLK = 1'h0;
  logic        RST = 1'h1;
  logic        CE = 1'h1;
  logic        CMD_VALID = 1'h0;
  logic        probe = 1'h0;
  logic        b;
  iobs_cmd_t   CMD = '0;
  iobs_bank_t  bs;
  logic [15:0] mi, ai, mo, moe, ao, aoe, pr, dr, orr;
  logic [15:0] r = 16'h8BCC;
  logic [15:0] d [2];
  logic [15:0] o [2];
  logic [96:0] q [$];
  logic [96:0] e;
  iobs_bank_t  nbs;
  logic [15:0] npr, nao, naoe;
  int          miscompares = 0;
  int          samples_checked = 0;
  always #2.5 SYS_CLK = ~SYS_CLK;
  iobs_top dut (.SYS_CLK(SYS_CLK), .RST(RST), .CE(CE), .CMD_VALID(CMD_VALID), .CMD(CMD),
    .MAIN_PIN_IN(mi), .MAIN_PIN_OUT(mo), .MAIN_PIN_OE_N(moe), .AUX_PIN_IN(ai),
    .AUX_PIN_OUT(ao), .AUX_PIN_OE_N(aoe), .BANK_SEL(bs), .SEL_PIN_READ(pr),
    .SEL_DIR_READ(dr), .SEL_OUT_READ(orr));
  // variant without auxiliary pins on the same command stream
  iobs_top #(.AUX_PRESENT(1'b0)) dut_bare (.SYS_CLK(SYS_CLK), .RST(RST), .CE(CE),
    .CMD_VALID(CMD_VALID), .CMD(CMD), .MAIN_PIN_IN(mi), .MAIN_PIN_OUT(), .MAIN_PIN_OE_N(),
    .AUX_PIN_IN(ai), .AUX_PIN_OUT(nao), .AUX_PIN_OE_N(naoe), .BANK_SEL(nbs),
    .SEL_PIN_READ(npr), .SEL_DIR_READ(), .SEL_OUT_READ());
  iobs_pins pm (.clk(SYS_CLK), .pin_out(mo), .pin_oe_n(moe), .pin_in(mi));
  iobs_pins pa (.clk(SYS_CLK), .pin_out(ao), .pin_oe_n(aoe), .pin_in(ai));
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge SYS_CLK);
    #1;
  endtask
  task automatic wrap_up();
    if (miscompares == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // hold reset for eight edges and clear the reference
  task automatic reset();
    RST = 1'h1;
    tick(8);
    RST = 1'h0;
    d = '{16'h0000, 16'h0000};
    o = '{16'h0000, 16'h0000};
    b = 1'h0;
  endtask
  // note the expected snapshot and strobe the watcher for one edge
  task automatic note();
    q.push_back({o[0], ~d[0], o[1], ~d[1], b, d[b], o[b]});
    probe = 1'h1;
    tick(1);
    probe = 1'h0;
  endtask
  // reference model of both banks
  task automatic upd();
    case (CMD.op)
      IOBS_OP_SEL_MAIN:    b = 1'h0;
      IOBS_OP_SEL_AUX:     b = 1'h1;
      IOBS_OP_SEL_VALUE:   b = CMD.sel_value;
      IOBS_OP_WR_DIR_WORD: d[b] = CMD.word;
      IOBS_OP_WR_OUT_WORD: o[b] = CMD.word;
      IOBS_OP_PIN_INPUT:   d[b][CMD.pin_id] = 1'h0;
      IOBS_OP_PIN_REVERSE: d[b][CMD.pin_id] ^= 1'h1;
      IOBS_OP_PIN_LOW:     o[b][CMD.pin_id] = 1'h0;
      IOBS_OP_PIN_HIGH:    o[b][CMD.pin_id] = 1'h1;
      IOBS_OP_PIN_TOGGLE:  o[b][CMD.pin_id] ^= 1'h1;
      default: ;
    endcase
    if (CMD.op inside {[IOBS_OP_PIN_OUTPUT:IOBS_OP_PIN_TOGGLE]})
      d[b][CMD.pin_id] = 1'h1;
  endtask
  // compare each probed snapshot with the oldest note, away from the clock edge
  always @(negedge SYS_CLK) if (probe) begin
    e = q.pop_front();
    samples_checked++;
    if ({mo, moe, ao, aoe, bs, dr, orr} !== e) begin
      miscompares++;
      $display("FAIL %0t snapshot mismatch", $time);
    end
    if ((pr & e[31:16]) !== (e[15:0] & e[31:16])) begin
      miscompares++;
      $display("FAIL %0t driven pin read mismatch", $time);
    end
    if ({nao, naoe} !== {16'h0000, 16'hFFFF}) begin
      miscompares++;
      $display("FAIL %0t absent aux pins driven", $time);
    end
    if (nbs !== e[32] || (e[32] && npr !== 16'hFFFF)) begin
      miscompares++;
      $display("FAIL %0t absent aux select or read mismatch", $time);
    end
  end
  // every command kind except IOBS_OP_NONE in turn, random operands and enable
  initial begin
    reset();
    note();
    for (int i = 0; i < 66; i++) begin
      if (i == 33) reset();
      r = lfsr_next(r);
      CMD = {iobs_op_t'(i % 11 + 1), r[3:0], r[4], r};
      CE = |r[6:5];
      CMD_VALID = 1'h1;
      if (CE) upd();
      tick(1);
      CMD_VALID = 1'h0;
      CE = 1'h1;
      tick(2);
      note();
    end
    wrap_up();
  end
  // watchdog
  initial begin
    #20000;
    miscompares++;
    wrap_up();
  end
endmodule
bind iobs_top iobs_monitor #(.AUX_ON(AUX_PRESENT)) mon (.SYS_CLK(SYS_CLK), .RST(RST), .CE(CE),
  .CMD_VALID(CMD_VALID),
  .CMD(CMD), .MAIN_PIN_OUT(MAIN_PIN_OUT), .MAIN_PIN_OE_N(MAIN_PIN_OE_N),
  .AUX_PIN_OUT(AUX_PIN_OUT), .AUX_PIN_OE_N(AUX_PIN_OE_N), .BANK_SEL(BANK_SEL));
